// ---- design/lbs_pkg.sv ----
// shared constants and types of the lamp ballast strike sequencer
package lbs_pkg;

    // system clock rate
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned CLK_KHZ          = CLK_MHZ * 1000;

    // timing integrator: recycle and preheat share one time base
    localparam int unsigned T_RECYCLE_MS     = 125;
    localparam int unsigned T_PREHEAT_MS     = 2000;
    localparam int unsigned PREHEAT_RATIO    = T_PREHEAT_MS / T_RECYCLE_MS;
    localparam int unsigned RECYCLE_CYC      = T_RECYCLE_MS * CLK_KHZ;
    localparam int unsigned T_BLANK_MS       = 10;
    localparam int unsigned BLANK_CYC        = T_BLANK_MS * CLK_KHZ;

    // sweep: half period grows by one cycle per step
    localparam int unsigned T_SWEEP_STEP_US  = 100;
    localparam int unsigned SWEEP_STEP_CYC   = T_SWEEP_STEP_US * CLK_MHZ;

    // dead time window, least rounds up, longest rounds down
    localparam int unsigned T_DT_MIN_NS      = 300;
    localparam int unsigned T_DT_MAX_NS      = 2500;
    localparam int unsigned DT_MIN_CYC       = (T_DT_MIN_NS * CLK_MHZ + 999)
                                               / 1000;
    localparam int unsigned DT_MAX_CYC       = (T_DT_MAX_NS * CLK_MHZ) / 1000;

    // attempts before full stop
    localparam int unsigned MAX_ATTEMPTS     = 4;

    // widths
    localparam int unsigned HALF_W           = 16;
    localparam int unsigned DT_W             = 10;
    localparam int unsigned INT_W            = 32;
    localparam int unsigned TICK_W           = 5;
    localparam int unsigned ATT_W            = 3;

    // reset values
    localparam logic [HALF_W-1:0] HALF_RST   = 16'h0000;
    localparam logic [INT_W-1:0]  INT_RST    = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_PREHEAT = 3'b000,
        ST_SWEEP   = 3'b001,
        ST_DWELL   = 3'b010,
        ST_BLANK   = 3'b011,
        ST_RUN     = 3'b100,
        ST_STOP    = 3'b101,
        ST_HOLD    = 3'b110
    } lbs_state_t;

    typedef enum logic [1:0] {
        GM_OFF     = 2'b00,
        GM_ALL_OFF = 2'b01,
        GM_ALT     = 2'b10
    } lbs_gate_mode_t;

endpackage

// ---- design/lbs_pin_sync.sv ----
// two-stage pin synchroniser with falling edge detect
`timescale 1ns/1ps
module lbs_pin_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_prev;

    always_comb begin
        nxt_meta = i_pin;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
            prev_ff <= INIT;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    assign o_level = sync_ff;
    assign o_fall  = prev_ff & ~sync_ff;
endmodule

// ---- design/lbs_gate_drive.sv ----
// half-bridge gate driver: 50 % master clock with dead time
`timescale 1ns/1ps
module lbs_gate_drive (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst,
    input  wire lbs_pkg::lbs_gate_mode_t       i_mode,
    input  wire logic [lbs_pkg::HALF_W-1:0]    i_half_period,
    input  wire logic [lbs_pkg::DT_W-1:0]      i_dead_cyc,
    output logic                               o_high_side_gate_out,
    output logic                               o_low_side_gate_out
);
    import lbs_pkg::*;

    logic [HALF_W-1:0] hp_cnt_ff;
    logic              phase_ff;
    logic [DT_W-1:0]   dt_cnt_ff;
    logic              ho_ff;
    logic              lo_ff;
    logic [HALF_W-1:0] nxt_hp_cnt;
    logic              nxt_phase;
    logic [DT_W-1:0]   nxt_dt_cnt;
    logic              nxt_ho;
    logic              nxt_lo;
    logic              dt_done;

    always_comb begin
        nxt_hp_cnt = hp_cnt_ff;
        nxt_phase  = phase_ff;
        nxt_dt_cnt = dt_cnt_ff;
        dt_done    = 1'b0;
        nxt_ho     = 1'b0;
        nxt_lo     = 1'b0;
        case (i_mode)
            GM_ALT: begin
                // phase flips each half period; both gates dark first
                if (hp_cnt_ff + 16'h1 >= i_half_period) begin
                    nxt_hp_cnt = HALF_RST;
                    nxt_phase  = ~phase_ff;
                    nxt_dt_cnt = '0;
                end else begin
                    nxt_hp_cnt = hp_cnt_ff + 16'h1;
                    if (dt_cnt_ff < i_dead_cyc) begin
                        nxt_dt_cnt = dt_cnt_ff + 10'h1;
                    end
                end
                dt_done = (nxt_dt_cnt >= i_dead_cyc);
                nxt_ho  = nxt_phase & dt_done;
                nxt_lo  = ~nxt_phase & dt_done;
            end
            GM_ALL_OFF: begin
                nxt_hp_cnt = HALF_RST;
                nxt_phase  = 1'b1;
                nxt_dt_cnt = '0;
            end
            default: begin
                // off state keeps bootstrap charged via low side
                nxt_hp_cnt = HALF_RST;
                nxt_phase  = 1'b1;
                nxt_dt_cnt = '0;
                nxt_lo     = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hp_cnt_ff <= HALF_RST;
            phase_ff  <= 1'b1;
            dt_cnt_ff <= '0;
            ho_ff     <= 1'b0;
            lo_ff     <= 1'b1;
        end else begin
            hp_cnt_ff <= nxt_hp_cnt;
            phase_ff  <= nxt_phase;
            dt_cnt_ff <= nxt_dt_cnt;
            ho_ff     <= nxt_ho;
            lo_ff     <= nxt_lo;
        end
    end

    assign o_high_side_gate_out = ho_ff;
    assign o_low_side_gate_out  = lo_ff;

    AST_NO_SHOOT_THROUGH: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        !(ho_ff && lo_ff))
        else $error("both gates on at once");

    AST_DEAD_GAP: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        // off state leaves the low gate lit for one cycle into the sweep
        (i_mode == GM_ALT && $past(i_mode) == GM_ALT && !$past(i_rst)
         && $stable(i_dead_cyc) && dt_cnt_ff < i_dead_cyc)
        |-> (!ho_ff && !lo_ff))
        else $error("gate on inside dead time");
endmodule

// ---- design/lbs_strike_seq.sv ----
// top: lamp ballast preheat, sweep, strike and retry sequencer
`timescale 1ns/1ps
module lbs_strike_seq #(
    parameter int unsigned RECYCLE_CYC    = lbs_pkg::RECYCLE_CYC,
    parameter int unsigned PREHEAT_RATIO  = lbs_pkg::PREHEAT_RATIO,
    parameter int unsigned BLANK_CYC      = lbs_pkg::BLANK_CYC,
    parameter int unsigned SWEEP_STEP_CYC = lbs_pkg::SWEEP_STEP_CYC
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst,
    input  wire logic                       i_master_rst_n,
    input  wire logic                       i_strike_detect_in,
    input  wire logic [lbs_pkg::HALF_W-1:0] i_preheat_frequency_half,
    input  wire logic [lbs_pkg::HALF_W-1:0] i_sweep_end_frequency_half,
    input  wire logic [lbs_pkg::HALF_W-1:0] i_run_frequency_half,
    input  wire logic [lbs_pkg::DT_W-1:0]   i_dead_time_adjust,
    output logic                            o_high_side_gate_out,
    output logic                            o_low_side_gate_out,
    output logic                            o_stopped,
    output logic                            o_lamp_running
);
    import lbs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic mrst_lvl;
    logic strike_fall;

    // pin idles high so an open reset pin never holds the block
    lbs_pin_sync #(
        .INIT       (1'b1)
    ) u_mrst_sync (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_pin      (i_master_rst_n),
        .o_level    (mrst_lvl),
        .o_fall     ()
    );

    // comparator output; any drop below low threshold is a strike
    lbs_pin_sync #(
        .INIT       (1'b0)
    ) u_strike_sync (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_pin      (i_strike_detect_in),
        .o_level    (),
        .o_fall     (strike_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer state

    lbs_state_t        state_ff;
    lbs_state_t        nxt_state;
    logic [INT_W-1:0]  int_cnt_ff;
    logic [INT_W-1:0]  nxt_int_cnt;
    logic [TICK_W-1:0] tick_cnt_ff;
    logic [TICK_W-1:0] nxt_tick_cnt;
    logic [ATT_W-1:0]  attempts_ff;
    logic [ATT_W-1:0]  nxt_attempts;
    logic [HALF_W-1:0] cur_half_ff;
    logic [HALF_W-1:0] nxt_cur_half;
    logic [INT_W-1:0]  step_cnt_ff;
    logic [INT_W-1:0]  nxt_step_cnt;
    logic [DT_W-1:0]   dead_ff;
    logic [DT_W-1:0]   nxt_dead;
    logic              stopped_ff;
    logic              running_ff;
    logic              int_done;
    logic              blank_done;
    logic              step_done;
    logic              attempt_fail;
    lbs_gate_mode_t    gate_mode;

    // one integrator times recycle, preheat (as a multiple) and blanking
    assign int_done   = (int_cnt_ff >= INT_W'(RECYCLE_CYC - 1));
    assign blank_done = (int_cnt_ff >= INT_W'(BLANK_CYC - 1));
    assign step_done  = (step_cnt_ff >= INT_W'(SWEEP_STEP_CYC - 1));

    always_comb begin
        nxt_state    = state_ff;
        nxt_int_cnt  = int_cnt_ff + 32'h1;
        nxt_tick_cnt = tick_cnt_ff;
        nxt_attempts = attempts_ff;
        nxt_cur_half = cur_half_ff;
        nxt_step_cnt = step_cnt_ff + 32'h1;
        attempt_fail = 1'b0;
        case (state_ff)
            ST_PREHEAT: begin
                nxt_cur_half = i_preheat_frequency_half;
                if (int_done) begin
                    nxt_int_cnt = INT_RST;
                    if (tick_cnt_ff == TICK_W'(PREHEAT_RATIO - 1)) begin
                        nxt_tick_cnt = '0;
                        nxt_step_cnt = INT_RST;
                        nxt_state    = ST_SWEEP;
                    end else begin
                        nxt_tick_cnt = tick_cnt_ff + 5'h1;
                    end
                end
            end
            ST_SWEEP: begin
                if (strike_fall) begin
                    nxt_cur_half = i_run_frequency_half;
                    nxt_state    = ST_RUN;
                end else if (int_done) begin
                    attempt_fail = 1'b1;
                end else if (cur_half_ff >= i_sweep_end_frequency_half) begin
                    nxt_cur_half = i_sweep_end_frequency_half;
                    nxt_state    = ST_DWELL;
                end else if (step_done) begin
                    // frequency falls as the half period grows
                    nxt_step_cnt = INT_RST;
                    nxt_cur_half = cur_half_ff + 16'h1;
                end
            end
            ST_DWELL: begin
                // integrator runs on from attempt start, so dwell is
                // recycle time less whatever the sweep used
                if (strike_fall) begin
                    nxt_cur_half = i_run_frequency_half;
                    nxt_state    = ST_RUN;
                end else if (int_done) begin
                    attempt_fail = 1'b1;
                end
            end
            ST_BLANK: begin
                // strike edges are not looked at here
                if (blank_done) begin
                    nxt_int_cnt  = INT_RST;
                    nxt_step_cnt = INT_RST;
                    nxt_cur_half = i_preheat_frequency_half;
                    nxt_state    = ST_SWEEP;
                end
            end
            ST_RUN: begin
                nxt_int_cnt  = int_cnt_ff;
                nxt_step_cnt = step_cnt_ff;
                nxt_cur_half = i_run_frequency_half;
            end
            ST_STOP: begin
                nxt_int_cnt  = int_cnt_ff;
                nxt_step_cnt = step_cnt_ff;
            end
            ST_HOLD: begin
                nxt_int_cnt  = INT_RST;
                nxt_step_cnt = INT_RST;
                nxt_cur_half = i_preheat_frequency_half;
                if (mrst_lvl) begin
                    nxt_state = ST_SWEEP;
                end
            end
            default: begin
                nxt_state = ST_STOP;
            end
        endcase

        if (attempt_fail) begin
            nxt_int_cnt = INT_RST;
            if (attempts_ff == ATT_W'(MAX_ATTEMPTS - 1)) begin
                nxt_state = ST_STOP;
            end else begin
                nxt_attempts = attempts_ff + 3'h1;
                nxt_state    = ST_BLANK;
            end
        end

        // no filtering: even a one-cycle low after sync resets
        if (!mrst_lvl) begin
            nxt_state    = ST_HOLD;
            nxt_int_cnt  = INT_RST;
            nxt_tick_cnt = '0;
            nxt_attempts = '0;
        end
    end

    always_comb begin
        if (i_dead_time_adjust < DT_W'(DT_MIN_CYC)) begin
            nxt_dead = DT_W'(DT_MIN_CYC);
        end else if (i_dead_time_adjust > DT_W'(DT_MAX_CYC)) begin
            nxt_dead = DT_W'(DT_MAX_CYC);
        end else begin
            nxt_dead = i_dead_time_adjust;
        end
    end

    // supply restart: only this reset re-runs the preheat interval
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_ff    <= ST_PREHEAT;
            int_cnt_ff  <= INT_RST;
            tick_cnt_ff <= '0;
            attempts_ff <= '0;
            cur_half_ff <= HALF_RST;
            step_cnt_ff <= INT_RST;
            dead_ff     <= DT_W'(DT_MIN_CYC);
            stopped_ff  <= 1'b0;
            running_ff  <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            int_cnt_ff  <= nxt_int_cnt;
            tick_cnt_ff <= nxt_tick_cnt;
            attempts_ff <= nxt_attempts;
            cur_half_ff <= nxt_cur_half;
            step_cnt_ff <= nxt_step_cnt;
            dead_ff     <= nxt_dead;
            stopped_ff  <= (nxt_state == ST_STOP);
            running_ff  <= (nxt_state == ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gate outputs

    always_comb begin
        case (state_ff)
            ST_HOLD:  gate_mode = GM_ALL_OFF;
            ST_STOP:  gate_mode = GM_OFF;
            ST_BLANK: gate_mode = GM_OFF;
            default:  gate_mode = GM_ALT;
        endcase
    end

    lbs_gate_drive u_gate (
        .i_clk_sys            (i_clk_sys),
        .i_rst                (i_rst),
        .i_mode               (gate_mode),
        .i_half_period        (cur_half_ff),
        .i_dead_cyc           (dead_ff),
        .o_high_side_gate_out (o_high_side_gate_out),
        .o_low_side_gate_out  (o_low_side_gate_out)
    );

    assign o_stopped      = stopped_ff;
    assign o_lamp_running = running_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_trying;
        (state_ff == ST_SWEEP || state_ff == ST_DWELL) && mrst_lvl;
    endsequence

    sequence s_fail;
        s_trying ##0 (!strike_fall && int_done);
    endsequence

    sequence s_release;
        state_ff == ST_HOLD && mrst_lvl;
    endsequence

    AST_STRIKE_TO_RUN: assert property (
        s_trying ##0 strike_fall
        |=> state_ff == ST_RUN && cur_half_ff == i_run_frequency_half)
        else $error("strike did not switch to run frequency");

    AST_STOP_AFTER_FOUR: assert property (
        s_fail ##0 (attempts_ff == 3'h3) |=> state_ff == ST_STOP ##1 o_stopped)
        else $error("fourth failed attempt did not stop");

    AST_ATTEMPT_COUNT: assert property (
        s_fail ##0 (attempts_ff < 3'h3)
        |=> attempts_ff == $past(attempts_ff) + 3'h1 && state_ff == ST_BLANK)
        else $error("failed attempt not counted");

    AST_STOP_STICKY: assert property (
        state_ff == ST_STOP && mrst_lvl |=> state_ff == ST_STOP)
        else $error("stop left without reset");

    AST_RESET_ENTRY: assert property (
        $fell(i_master_rst_n) |-> ##[1:3] state_ff == ST_HOLD)
        else $error("master reset not entered in time");

    AST_HOLD_GATES_OFF: assert property (
        state_ff == ST_HOLD |=> !o_high_side_gate_out && !o_low_side_gate_out)
        else $error("gate on during master reset");

    AST_RELEASE_SWEEP: assert property (
        s_release |=> state_ff == ST_SWEEP && attempts_ff == 3'h0
                      && cur_half_ff == i_preheat_frequency_half)
        else $error("release did not start sweep at preheat frequency");

    AST_BLANK_IGNORE: assert property (
        state_ff == ST_BLANK && strike_fall && mrst_lvl
        |=> state_ff != ST_RUN)
        else $error("strike accepted during blanking");

    AST_DWELL_HOLDS: assert property (
        state_ff == ST_DWELL && !int_done && !strike_fall && mrst_lvl
        |=> state_ff == ST_DWELL)
        else $error("dwell ended before recycle time");

    AST_PREHEAT_RATIO: assert property (
        state_ff == ST_PREHEAT && mrst_lvl && int_done
        && tick_cnt_ff == TICK_W'(PREHEAT_RATIO - 1) |=> state_ff == ST_SWEEP)
        else $error("preheat not ended at ratio of recycle time");

    AST_OFF_STATE: assert property (
        state_ff == ST_STOP |=> !o_high_side_gate_out && o_low_side_gate_out)
        else $error("off state gates wrong");
endmodule

// ---- bench/lbs_lamp_model.sv ----
// strike-sense source and half-bridge watcher for the sequencer bench
`timescale 1ns/1ps
module lbs_lamp_model (
    input  wire logic i_clk_sys,
    input  wire logic i_fire,
    input  wire logic i_high_side_gate_out,
    input  wire logic i_low_side_gate_out,
    output logic      o_strike_detect_in,
    output logic      o_shoot_through
);
    int unsigned cnt = 0;
    initial o_strike_detect_in = 1'b1;
    initial o_shoot_through = 1'b0;
    always @(posedge i_clk_sys) begin
        // sticky: a single overlap would destroy the bridge
        if (i_high_side_gate_out && i_low_side_gate_out) begin
            o_shoot_through <= 1'b1;
        end
        if (i_fire && cnt == 0) begin
            cnt <= 1;
        end else if (cnt != 0) begin
            cnt <= (cnt == 600) ? 0 : cnt + 1;
        end
        // high 300 cycles before the fall, then low 301 cycles
        o_strike_detect_in <= !(cnt >= 300);
    end
endmodule

// ---- bench/lbs_strike_seq_bench.sv ----
// self-checking bench of the lamp ballast strike sequencer
`timescale 1ns/1ps
module lbs_strike_seq_bench;
    import lbs_pkg::*;
    localparam int MRST_HOLD = 2500; // ten microseconds of 4 ns cycles
    localparam int RUN_H     = 150;
    localparam int DEAD      = 80;
    logic i_clk_sys      = 1'b0;
    logic i_rst          = 1'b1;
    logic master_rst_n   = 1'b0;
    logic fire           = 1'b0;
    logic strike_in;
    logic [HALF_W-1:0] preheat_half = 16'h0064;
    logic [HALF_W-1:0] end_half     = 16'h006e;
    logic [HALF_W-1:0] run_half     = HALF_W'(RUN_H);
    logic [DT_W-1:0]   dead_adj     = DT_W'(DEAD);
    logic hi;
    logic lo;
    logic shoot;
    logic stopped;
    logic running;
    int   n_fail         = 0;
    int   check_count    = 0;
    initial begin
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    lbs_lamp_model lbs_lamp_model_i (
        .i_clk_sys(i_clk_sys), .i_fire(fire), .i_high_side_gate_out(hi),
        .i_low_side_gate_out(lo), .o_strike_detect_in(strike_in),
        .o_shoot_through(shoot));
    // short counts keep the run small; the ratio stays meaningful
    lbs_strike_seq #(.RECYCLE_CYC(200), .PREHEAT_RATIO(4), .BLANK_CYC(50),
        .SWEEP_STEP_CYC(5)) lbs_strike_seq_i (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_master_rst_n(master_rst_n), .i_strike_detect_in(strike_in),
        .i_preheat_frequency_half(preheat_half),
        .i_sweep_end_frequency_half(end_half),
        .i_run_frequency_half(run_half), .i_dead_time_adjust(dead_adj),
        .o_high_side_gate_out(hi), .o_low_side_gate_out(lo),
        .o_stopped(stopped), .o_lamp_running(running));
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return running;
            1: return stopped;
            default: return !hi && !lo;
        endcase
    endfunction
    task automatic wait_for(input int sel, input int n);
        int k;
        k = 0;
        while (pick(sel) !== 1'b1 && k < n) begin
            tick(1);
            k++;
        end
        check_count++;
        if (pick(sel) !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t wait %0d ran out", $time, sel);
            wrap_up();
        end
    endtask
    task automatic count_while(input logic v, output int n);
        n = 0;
        while (hi === v && n < 1000) begin
            tick(1);
            n++;
        end
        if (n >= 1000) begin
            n_fail++;
            $display("ERROR %0t high gate stuck", $time);
            wrap_up();
        end
    endtask
    // skip a partial on and off stretch, then time one full period
    task automatic measure(output int n_on, output int n_off);
        int skip;
        count_while(1'b1, skip);
        count_while(1'b0, skip);
        count_while(1'b1, n_on);
        count_while(1'b0, n_off);
    endtask
    task automatic strike();
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
    endtask
    task automatic do_reset();
        i_rst = 1'b1;
        master_rst_n = 1'b0;
        tick(2);
        check(hi, 1'b0, "high gate on in reset");
        check(lo, 1'b1, "low gate off in reset");
        // supply and master reset come back in the same step
        i_rst = 1'b0;
        master_rst_n = 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_preheat();
        do_reset();
        strike();
        tick(700);
        check(running, 1'b0, "strike taken in preheat");
        tick(300);
    endtask
    task automatic t_strike();
        int n_on;
        int n_off;
        do_reset();
        tick(550);
        strike();
        wait_for(0, 400);
        measure(n_on, n_off);
        check(n_on + n_off == 2 * RUN_H, 1'b1, "run period");
        check(n_on == RUN_H - DEAD, 1'b1, "dead time");
        // below the least dead time the block clamps
        dead_adj = 10'h000;
        tick(300);
        measure(n_on, n_off);
        check(n_on == RUN_H - DT_MIN_CYC, 1'b1, "dead clamp");
        check(shoot, 1'b0, "both gates on");
    endtask
    task automatic t_master();
        logic lit;
        lit = 1'b0;
        master_rst_n = 1'b0;
        tick(4);
        check(running, 1'b0, "run kept in reset");
        strike();
        // recommended 10 ms is scaled down like the other timings
        repeat (MRST_HOLD) begin
            tick(1);
            lit = lit | hi | lo;
        end
        check(lit, 1'b0, "gate on in reset");
        check(running, 1'b0, "strike taken in reset");
        master_rst_n = 1'b1;
        // a preheat here would hide the strike for 800 cycles
        strike();
        wait_for(0, 400);
    endtask
    task automatic t_stop();
        tick(700);
        master_rst_n = 1'b0;
        tick(MRST_HOLD);
        master_rst_n = 1'b1;
        // the fall lands in the second blanking gap
        tick(165);
        strike();
        tick(534);
        check(running, 1'b0, "strike taken in blanking");
        check(stopped, 1'b0, "stop before fourth try");
        wait_for(1, 400);
        tick(1);
        check(hi, 1'b0, "high gate on in stop");
        check(lo, 1'b1, "low gate off in stop");
        strike();
        tick(700);
        check(stopped, 1'b1, "stop left by strike");
        check(running, 1'b0, "strike taken in stop");
        // no filtering: a short low resets as well
        master_rst_n = 1'b0;
        tick(10);
        master_rst_n = 1'b1;
        tick(700);
        check(stopped, 1'b0, "attempts not cleared");
    endtask
    initial begin
        t_preheat();
        t_strike();
        t_master();
        t_stop();
        wrap_up();
    end
endmodule
